// ==== hdl/wes_wake_defines.svh ====
/*
  offsets, field positions, reset values and sync depth for the wake-event
  status block; assumes inclusion by bare name from the design files.
*/
`ifndef WES_WAKE_DEFINES_SVH
`define WES_WAKE_DEFINES_SVH

`define WES_OFS_SUMMARY_STATUS 4'h0
`define WES_OFS_GLOBAL_ENABLE  4'h1
`define WES_OFS_SOURCE_STS_ONE 4'h2

`define WES_SUMMARY_FLAG_BIT   0
`define WES_GLOBAL_EN_BIT      0

`define WES_RST_SUMMARY_STATUS 8'h00
`define WES_RST_GLOBAL_ENABLE  8'h00
`define WES_RST_SOURCE_STS_ONE 8'h00
`define WES_RDATA_UNMAPPED     8'h00

`define WES_SRC_COUNT          8
`define WES_SYNC_DEPTH         2'h3

`endif

// ==== hdl/wes_wake_pkg.sv ====
/*
  types shared by the wake-event status block; assumes nothing beyond
  a SystemVerilog compiler.
*/
package wes_wake_pkg;

  typedef logic [7:0] wes_byte_type;
  typedef logic [3:0] wes_offset_type;

endpackage

// ==== hdl/wes_wake_status.sv ====
/*
  wake-event status logic: eight pin sources latch sticky wake status,
  a summary flag and a global enable gate the open-drain wake output.
  assumes resetn_i is the standby-supply power-on reset, and that the
  register port is driven by same-clock decode logic of the I/O block.
*/
// What this block does
// - summary flag sets whenever the wake output would assert, enable aside
// - summary flag sets when any source status and its enable are both 1
// - summary flag ignores main-supply, soft and hard resets
// - writing 1 to the summary flag clears it and drops the wake output, if no enabled source status is pending
// - writing 0 to the summary flag leaves it alone
// - global enable bit 0 blocks the wake output when 0, default 0
// - global enable ignores main-supply, soft and hard resets
// - source status bits 0 to 7 map to pins ten to seventeen
// - source status records events regardless of source and global enables, but only on clocks with ce_i high
// - a latched source status bit reads 1 until software clears it
// - source status ignores main-supply, soft and hard resets
// - writing 1 clears a source status bit, writing 0 leaves it
// - reserved bits read 0, including bits 7 to 1 of flag and enable
// - a rising pin edge sets its source status bit
// - pending source bits must be cleared before the flag can clear
`include "wes_wake_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module wes_wake_status (
  input  wire logic                         mclk_i,
  input  wire logic                         resetn_i,
  input  wire logic                         ce_i,
  input  wire wes_wake_pkg::wes_offset_type reg_addr_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  input  wire wes_wake_pkg::wes_byte_type   reg_wdata_i,
  output logic [7:0]                        reg_rdata_o,
  input  wire logic [7:0]                   src_enable_i,
  input  wire logic                         gen_pin_ten_i,
  input  wire logic                         gen_pin_eleven_i,
  input  wire logic                         gen_pin_twelve_i,
  input  wire logic                         gen_pin_thirteen_i,
  input  wire logic                         gen_pin_fourteen_i,
  input  wire logic                         gen_pin_fifteen_i,
  input  wire logic                         gen_pin_sixteen_i,
  input  wire logic                         gen_pin_seventeen_i,
  output logic                              wake_event_out_o,
  output logic                              wake_event_oe_n_o
);

  logic [7:0] pin_vec;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] sync3_reg;
  logic [7:0] pin_level_reg;
  logic [7:0] pin_known_reg;
  logic [7:0] edge_vec;
  logic [7:0] source_sts_reg;
  logic [7:0] source_sts_next;
  logic       summary_flag_reg;
  logic       summary_flag_next;
  logic       global_en_reg;
  logic       pending;
  logic       wr_summary;
  logic       wr_global;
  logic       wr_source;
  logic       wake_assert;
  logic [7:0] rdata_next;
  logic [1:0] prime_reg;

  // reset values as constants so a single field can be picked out of them
  localparam logic [7:0] rst_summary_status = `WES_RST_SUMMARY_STATUS;
  localparam logic [7:0] rst_global_enable  = `WES_RST_GLOBAL_ENABLE;

  // pin order fixes the status bit order, lowest pin in bit 0
  assign pin_vec = {gen_pin_seventeen_i, gen_pin_sixteen_i,
                    gen_pin_fifteen_i, gen_pin_fourteen_i,
                    gen_pin_thirteen_i, gen_pin_twelve_i,
                    gen_pin_eleven_i, gen_pin_ten_i};

  assign wr_summary = reg_wr_i && (reg_addr_i == `WES_OFS_SUMMARY_STATUS);
  assign wr_global  = reg_wr_i && (reg_addr_i == `WES_OFS_GLOBAL_ENABLE);
  assign wr_source  = reg_wr_i && (reg_addr_i == `WES_OFS_SOURCE_STS_ONE);

  // the chain holds reset zeros, not pin samples, until three enabled
  // clocks have filled it; no baseline is taken before then
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prime_reg <= 2'h0;
    end else if (ce_i && (prime_reg != `WES_SYNC_DEPTH)) begin
      prime_reg <= prime_reg + 2'h1;
    end
  end

  // three stages; a level only counts once stages two and three agree,
  // which filters single-cycle glitches at the cost of latency
  genvar gi;
  generate
    for (gi = 0; gi < `WES_SRC_COUNT; gi = gi + 1) begin : g_pin
      always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          sync1_reg[gi]     <= 1'b0;
          sync2_reg[gi]     <= 1'b0;
          sync3_reg[gi]     <= 1'b0;
          pin_level_reg[gi] <= 1'b0;
          pin_known_reg[gi] <= 1'b0;
        end else if (ce_i) begin
          sync1_reg[gi] <= pin_vec[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if ((prime_reg == `WES_SYNC_DEPTH)
              && (sync2_reg[gi] == sync3_reg[gi])) begin
            pin_level_reg[gi] <= sync3_reg[gi];
            pin_known_reg[gi] <= 1'b1;
          end
        end
      end
      // first agreed level after reset is taken as a baseline, not an edge,
      // so a pin already high at power-on raises no event
      assign edge_vec[gi] = pin_known_reg[gi]
                          && (sync2_reg[gi] == sync3_reg[gi])
                          && sync3_reg[gi] && !pin_level_reg[gi];
    end
  endgenerate

  // set beats a write-one clear landing in the same cycle
  always_comb begin
    source_sts_next = source_sts_reg;
    if (wr_source) begin
      source_sts_next = source_sts_next & ~reg_wdata_i;
    end
    source_sts_next = source_sts_next | edge_vec;
  end

  // resetn_i is the standby-supply power-on reset only; main-supply,
  // soft and hard resets never reach this register
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      source_sts_reg <= `WES_RST_SOURCE_STS_ONE;
    end else if (ce_i) begin
      source_sts_reg <= source_sts_next;
    end
  end

  assign pending = |(source_sts_reg & src_enable_i);

  // a still-pending source re-sets the flag at once, so the clear only
  // sticks after the source bits are gone
  always_comb begin
    summary_flag_next = summary_flag_reg;
    if (wr_summary && reg_wdata_i[`WES_SUMMARY_FLAG_BIT]) begin
      summary_flag_next = 1'b0;
    end
    if (pending) begin
      summary_flag_next = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      summary_flag_reg <= rst_summary_status[`WES_SUMMARY_FLAG_BIT];
    end else if (ce_i) begin
      summary_flag_reg <= summary_flag_next;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      global_en_reg <= rst_global_enable[`WES_GLOBAL_EN_BIT];
    end else if (ce_i && wr_global) begin
      global_en_reg <= reg_wdata_i[`WES_GLOBAL_EN_BIT];
    end
  end

  // open drain, active low: pull low only while flag and enable are set
  assign wake_assert = summary_flag_reg && global_en_reg;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_event_out_o  <= 1'b1;
      wake_event_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      wake_event_out_o  <= !wake_assert;
      wake_event_oe_n_o <= !wake_assert;
    end
  end

  // reads have no side effects; data appears the cycle after the strobe
  always_comb begin
    rdata_next = `WES_RDATA_UNMAPPED;
    case (reg_addr_i)
      `WES_OFS_SUMMARY_STATUS: rdata_next = {7'h00, summary_flag_reg};
      `WES_OFS_GLOBAL_ENABLE:  rdata_next = {7'h00, global_en_reg};
      `WES_OFS_SOURCE_STS_ONE: rdata_next = source_sts_reg;
      default:                 rdata_next = `WES_RDATA_UNMAPPED;
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= `WES_RDATA_UNMAPPED;
    end else if (ce_i && reg_rd_i) begin
      reg_rdata_o <= rdata_next;
    end
  end

  flag_set_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && |(source_sts_reg & src_enable_i)) |=> summary_flag_reg)
    else $error("summary flag not set by pending source");

  flag_clear_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && wr_summary && reg_wdata_i[0]
      && !(|(source_sts_reg & src_enable_i)))
    |=> !summary_flag_reg ##1 (!$past(ce_i) || wake_event_oe_n_o))
    else $error("summary flag clear did not drop wake output");

  flag_hold_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && wr_summary && !reg_wdata_i[0] && summary_flag_reg)
    |=> summary_flag_reg)
    else $error("zero write changed summary flag");

  wake_gate_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && !(summary_flag_reg && global_en_reg))
    |=> (wake_event_oe_n_o && wake_event_out_o))
    else $error("wake output driven while gated off");

  wake_drive_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && summary_flag_reg && global_en_reg)
    |=> (!wake_event_oe_n_o && !wake_event_out_o))
    else $error("wake output not driven when flag and enable set");

  enable_write_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && wr_global) |=> (global_en_reg == $past(reg_wdata_i[0])))
    else $error("global enable did not take written value");

  source_clear_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && wr_source)
    |=> ((source_sts_reg & $past(reg_wdata_i) & ~$past(edge_vec))
         == 8'h00))
    else $error("write one did not clear source status");

  source_sticky_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (!(ce_i && wr_source))
    |=> ((source_sts_reg & $past(source_sts_reg))
         == $past(source_sts_reg)))
    else $error("source status bit dropped without a clear");

  edge_set_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && |edge_vec)
    |=> ((source_sts_reg & $past(edge_vec)) == $past(edge_vec)))
    else $error("rising pin edge did not set source status");

  pin_latency_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && pin_known_reg[0] && !pin_level_reg[0] && !sync3_reg[0]
      && sync2_reg[0] && sync1_reg[0] && pin_vec[0])
    ##1 ce_i |-> edge_vec[0])
    else $error("pin edge not seen three samples later");

  reserved_read_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && reg_rd_i && (reg_addr_i == `WES_OFS_SUMMARY_STATUS
      || reg_addr_i == `WES_OFS_GLOBAL_ENABLE))
    |=> (reg_rdata_o[7:1] == 7'h00))
    else $error("reserved bits read nonzero");

  flag_sticky_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (summary_flag_reg && !(ce_i && wr_summary && reg_wdata_i[0]))
    |=> summary_flag_reg)
    else $error("summary flag dropped without a clear");

  flag_pending_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && wr_summary && reg_wdata_i[0]
      && |(source_sts_reg & src_enable_i))
    |=> summary_flag_reg)
    else $error("summary flag cleared while a source is pending");

  set_cause_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (!source_sts_reg[0] && !(ce_i && edge_vec[0]))
    |=> !source_sts_reg[0])
    else $error("source status set without a pin edge");

  source_read_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && reg_rd_i && (reg_addr_i == `WES_OFS_SOURCE_STS_ONE))
    |=> (reg_rdata_o == $past(source_sts_reg)))
    else $error("source status read back wrong");

  freeze_hold_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (!ce_i) |=> ($stable(source_sts_reg) && $stable(summary_flag_reg)
      && $stable(global_en_reg) && $stable(reg_rdata_o)
      && $stable(wake_event_oe_n_o)))
    else $error("state changed while clock enable low");

endmodule

`default_nettype wire

// ==== verif/wes_chipset_model.sv ====
/*
  chipset side of the wake line: resolves the open-drain output
  against the board pull-up. assumes one clock shared with the block.
*/
`timescale 1ns/1ns
`default_nettype none

module wes_chipset_model (
  input  wire logic mclk_i,
  input  wire logic wake_event_out_i,
  input  wire logic wake_event_oe_n_i,
  output logic      wake_level_o,
  output logic      wake_seen_o
);
  // pull-up wins whenever the block lets go of the line
  assign wake_level_o = wake_event_oe_n_i ? 1'b1 : wake_event_out_i;

  // registered, inverted copy, as the chipset samples the line on its clock
  always_ff @(posedge mclk_i) begin
    wake_seen_o <= ~wake_level_o;
  end
endmodule

`default_nettype wire

// ==== verif/tb_wes_wake_status.sv ====
/*
  bench for wes_wake_status: a row loop of pin events, then hand tests.
  assumes the design files and wes_chipset_model compile before it.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_wes_wake_status;
  typedef struct packed {
    logic [7:0] pins;
    logic [7:0] src_en;
    logic [7:0] exp_sts;
    logic       exp_flag;
  } wes_row_type;

  logic                         mclk_i   = 1'b0;
  logic                         resetn_i = 1'b0;
  logic                         ce_i     = 1'b1;
  logic                         reg_wr   = 1'b0;
  logic                         reg_rd   = 1'b0;
  wes_wake_pkg::wes_offset_type reg_addr = 4'h0;
  wes_wake_pkg::wes_byte_type   wdata    = 8'h00;
  logic [7:0]                   src_en   = 8'h00;
  logic [7:0]                   pins     = 8'h00;
  logic [7:0]                   rdata;
  logic [7:0]                   d;
  logic                         wake_out;
  logic                         wake_oe_n;
  logic                         wake_level;
  logic                         wake_seen;
  int                           n_errors = 0;
  int                           compares = 0;
  wes_row_type                  rows [5];

  always #4 mclk_i = ~mclk_i;

  wes_wake_status DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .src_enable_i(src_en),
    .gen_pin_ten_i(pins[0]), .gen_pin_eleven_i(pins[1]),
    .gen_pin_twelve_i(pins[2]), .gen_pin_thirteen_i(pins[3]),
    .gen_pin_fourteen_i(pins[4]), .gen_pin_fifteen_i(pins[5]),
    .gen_pin_sixteen_i(pins[6]), .gen_pin_seventeen_i(pins[7]),
    .wake_event_out_o(wake_out), .wake_event_oe_n_o(wake_oe_n));

  wes_chipset_model partner (.mclk_i(mclk_i), .wake_event_out_i(wake_out),
    .wake_event_oe_n_i(wake_oe_n), .wake_level_o(wake_level),
    .wake_seen_o(wake_seen));

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask

  // each op waits an edge first, so strobes never toggle twice a step
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    #1 reg_addr = a;
    wdata  = v;
    reg_wr = 1'b1;
    @(posedge mclk_i);
    #1 reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk_i);
    #1 reg_rd = 1'b0;
    d = rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic close_out;
    if (n_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    n_errors++;
    close_out();
  end

  initial begin
    rows[0] = {8'h01, 8'h01, 8'h01, 1'b1};
    rows[1] = {8'h02, 8'h00, 8'h02, 1'b0};
    rows[2] = {8'h80, 8'h80, 8'h80, 1'b1};
    rows[3] = {8'ha5, 8'h0f, 8'ha5, 1'b1};
    rows[4] = {8'h5a, 8'ha5, 8'h5a, 1'b0};
    cyc(2);
    resetn_i = 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd((a == 3) ? 4'hf : a[3:0]);
      check("reset value", 8'h00, d);
    end
    // global enable off: status and flag still latch, line stays up
    foreach (rows[i]) begin
      src_en = rows[i].src_en;
      pins   = rows[i].pins;
      cyc(8);
      rd(4'h2);
      check("source status", rows[i].exp_sts, d);
      rd(4'h0);
      check("summary", {7'h00, rows[i].exp_flag}, d);
      check("line idle", 8'h01, {7'h00, wake_level});
      pins = 8'h00;
      wr(4'h2, 8'hff);
      wr(4'h0, 8'h01);
      rd(4'h2);
      check("source cleared", 8'h00, d);
    end
    wr(4'h1, 8'hff);
    rd(4'h1);
    check("enable read", 8'h01, d);
    // clock enable low: the write must not land
    ce_i = 1'b0;
    wr(4'h1, 8'h00);
    ce_i = 1'b1;
    rd(4'h1);
    check("enable frozen", 8'h01, d);
    src_en = 8'h04;
    pins   = 8'h04;
    cyc(8);
    check("line driven", 8'h00, {7'h00, wake_level});
    check("chipset seen", 8'h01, {7'h00, wake_seen});
    wr(4'h0, 8'h01);
    rd(4'h0);
    check("flag pending", 8'h01, d);
    wr(4'h2, 8'hfb);
    rd(4'h2);
    check("sticky status", 8'h04, d);
    // source gone: only the flag's own stickiness keeps it now
    wr(4'h2, 8'h04);
    wr(4'h0, 8'h00);
    rd(4'h0);
    check("flag kept", 8'h01, d);
    wr(4'h0, 8'h01);
    rd(4'h0);
    check("flag cleared", 8'h00, d);
    check("line released", 8'h01, {7'h00, wake_level});
    // pin still high: a level is no new edge
    cyc(6);
    rd(4'h2);
    check("no edge", 8'h00, d);
    // standby reset with the pin held high: a baseline, not an event
    resetn_i = 1'b0;
    cyc(2);
    resetn_i = 1'b1;
    cyc(8);
    rd(4'h2);
    check("no edge after reset", 8'h00, d);
    rd(4'h1);
    check("enable default", 8'h00, d);
    close_out();
  end
endmodule

`default_nettype wire
